// *** bench/omps_ext_mem.sv ***
// Purpose: Expansion bus partner that reports which external spaces it answers.
// Assumes: Decode levels from the block are stable between bus cycles.
// Notes:   Behavioural; it answers only where the map hands space outside.
`timescale 1ns/1ps
module omps_ext_mem
  import omps_pkg::*;
(
  input  wire logic [15:0] port_roles,
  input  wire logic        marked_region_external,
  input  wire logic        shared_ram_onchip,
  output logic             ext_space_live,
  output logic             ext_ram_live
);
  // Memory sees cycles only while port A carries addresses and the space is external.
  assign ext_space_live = marked_region_external && (port_roles[1:0] == ROLE_ADDR);
  assign ext_ram_live   = marked_region_external && !shared_ram_onchip;
endmodule

// *** bench/omps_top_monitor.sv ***
// Purpose: Port-level assertions for the operating mode pin function block.
// Assumes: One clock domain; clk_en is low only while the bus is idle.
// Notes:   Roles lag the mode state by one cycle, so relations avoid that edge.
`timescale 1ns/1ps
module omps_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] port_roles,
  input wire logic        rom_enable,
  input wire logic        bus_16bit,
  input wire logic        single_chip,
  input wire logic        advanced_mode,
  input wire logic        marked_region_external,
  input wire logic        shared_ram_onchip,
  input wire logic        flash_user_mode,
  input wire logic        mode_unsupported
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // An access phase is answered after one wait state by a single pulse.
  sequence s_access;
    psel && penable && !pready && clk_en;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("access not answered by a one cycle ready pulse");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("error response without ready or with nonzero data");
  a_adv_mode: assert property (advanced_mode)
    else $error("advanced addressing not reported");
  a_single_gpio: assert property (single_chip |-> rom_enable && port_roles == 16'h0000)
    else $error("single chip operation drives a non port role");
  a_unsup_idle: assert property (mode_unsupported |-> !rom_enable && port_roles == 16'h0000)
    else $error("unsupported mode defines pin roles");
  a_ram_shared: assert property (!marked_region_external |-> shared_ram_onchip)
    else $error("shared region left off chip while expansion is off");
  a_flash_cause: assert property ($rose(flash_user_mode) |->
      $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("flash user mode entered without a register write");
  a_expand_wide: assert property ($fell(single_chip) |-> ##[0:2] bus_16bit)
    else $error("expanded entry did not widen the bus");
endmodule

bind omps_top omps_top_monitor omps_top_monitor_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_roles(port_roles), .rom_enable(rom_enable), .bus_16bit(bus_16bit),
  .single_chip(single_chip), .advanced_mode(advanced_mode),
  .marked_region_external(marked_region_external), .shared_ram_onchip(shared_ram_onchip),
  .flash_user_mode(flash_user_mode), .mode_unsupported(mode_unsupported));

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for mode decode, pin roles and map control.
// Assumes: APB answers after one wait state; clk_en drops only while idle.
// Notes:   Every mode code is visited through a fresh reset.
`timescale 1ns/1ps
module tb_top;
  import omps_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [2:0]  mode_select_pins = 3'h0;
  logic        boot_select_pin = 1'b0, clk_en = 1'b1, pready, pslverr, err;
  logic [15:0] port_roles;
  logic        rom_enable, bus_16bit, single_chip, advanced_mode, marked_region_external;
  logic        shared_ram_onchip, flash_user_mode, mode_unsupported, ext_space, ext_ram;
  logic [10:0] e, k;
  int          err_total = 0, tests_run = 0;

  omps_top #(.FLASH_VARIANT(1'b1)) omps_top_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_select_pins(mode_select_pins),
    .boot_select_pin(boot_select_pin), .port_roles(port_roles), .rom_enable(rom_enable),
    .bus_16bit(bus_16bit), .single_chip(single_chip), .advanced_mode(advanced_mode),
    .marked_region_external(marked_region_external), .shared_ram_onchip(shared_ram_onchip),
    .flash_user_mode(flash_user_mode), .mode_unsupported(mode_unsupported));
  omps_ext_mem omps_ext_mem_inst (
    .port_roles(port_roles), .marked_region_external(marked_region_external),
    .shared_ram_onchip(shared_ram_onchip), .ext_space_live(ext_space),
    .ext_ram_live(ext_ram));

  // Free running 20 MHz clock.
  always #25 pclk = ~pclk;

  task automatic complete_run();
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One APB transfer; held until ready is sampled, then two idle edges let roles settle.
  // Only the watchdog ends a wait that never sees ready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Straps the mode, resets for ten cycles and polls up to thirty status reads until the mode is latched.
  task automatic go(input logic [3:0] m);
    presetn <= 1'b0; mode_select_pins <= m[2:0]; boot_select_pin <= m[3];
    repeat (10) @(posedge pclk);
    chk(shared_ram_onchip, 1'b1);
    presetn <= 1'b1;
    repeat (30) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rd[ST_READY] === 1'b1) break;
    end
    chk(rd[ST_READY], 1'b1);
  endtask

  // Expected {unsupported, rom, single, expansion, bus16, role A, role D, role E}.
  function automatic logic [10:0] exp_of(input logic [3:0] m);
    logic [3:0] b;
    b = (m >= 4'hC) ? m - 4'h8 : (m == 4'hA) ? 4'h4 : (m == 4'hB || m == 4'h3) ? 4'h7 : m;
    case (b)
      4'h1: return 11'b00011011010;
      4'h2: return 11'b00010011000;
      4'h4: return 11'b01010001000;
      4'h5: return 11'b01011011010;
      4'h6: return 11'b01010011000;
      4'h7: return 11'b01100000000;
      default: return 11'b10000000000;
    endcase
  endfunction

  // Watchdog ends a hung run through the normal closing path.
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end

  initial begin
    @(posedge pclk);
    for (int m = 0; m < 16; m++) begin
      go(m[3:0]);
      e = exp_of(m[3:0]);
      k = (e[10] | e[8]) ? 11'h73F : 11'h7FF;
      chk({mode_unsupported, rom_enable, single_chip, marked_region_external, bus_16bit,
           port_roles[1:0], port_roles[7:6], port_roles[9:8]} & k, e & k);
      apb(1'b0, OFS_MODE_CTRL, 32'h0);
      chk(rd[2:0], m[2:0]);
      chk(advanced_mode, 1'b1);
    end
    go(MODE_7);
    apb(1'b0, OFS_SYS_CTRL, 32'h0);
    chk(rd, 32'h000000C1);
    apb(1'b1, OFS_SYS_CTRL, 32'h000000C0);
    chk(shared_ram_onchip, 1'b1);
    apb(1'b1, OFS_SYS_CTRL, 32'h000000C3);
    chk({single_chip, marked_region_external, bus_16bit}, 3'b011);
    apb(1'b0, OFS_AREA_W, 32'h0);
    chk(rd, {24'h0, AREA_ALL16});
    chk(port_roles[9:0], 10'h280);
    apb(1'b1, OFS_PORT_CFG, 32'h00000001);
    chk({port_roles[1:0], ext_space}, {ROLE_ADDR, 1'b1});
    apb(1'b1, OFS_SYS_CTRL, 32'h000000C2);
    chk({shared_ram_onchip, ext_ram}, 2'b01);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    go(MODE_1);
    apb(1'b1, OFS_SYS_CTRL, 32'h000000C1);
    apb(1'b0, OFS_SYS_CTRL, 32'h0);
    chk(rd[SYS_EXPANSION_ENABLE_BIT_POS], 1'b1);
    apb(1'b1, OFS_AREA_W, 32'h0000007F);
    chk(bus_16bit, 1'b1);
    apb(1'b1, OFS_AREA_W, {24'h0, AREA_ALL8});
    chk(bus_16bit, 1'b0);
    go(MODE_2);
    apb(1'b1, OFS_AREA_W, 32'h000000FE);
    chk(bus_16bit, 1'b0);
    apb(1'b1, OFS_AREA_W, {24'h0, AREA_ALL16});
    chk({bus_16bit, port_roles[9:8]}, {1'b1, ROLE_DATA});
    go(MODE_4);
    apb(1'b1, OFS_AREA_W, 32'h00000001);
    chk({bus_16bit, port_roles[9:8]}, {1'b1, ROLE_DATA});
    apb(1'b1, OFS_PORT_CFG, 32'h00000001);
    chk(port_roles[1:0], ROLE_ADDR);
    go(MODE_5);
    apb(1'b1, OFS_AREA_W, 32'h000000FE);
    chk(bus_16bit, 1'b0);
    go(MODE_12);
    apb(1'b1, OFS_FLASH1, 32'h00000040);
    chk(flash_user_mode, 1'b1);
    chk(shared_ram_onchip, 1'b1);
    // A low clock enable keeps the block frozen in its reset state.
    presetn <= 1'b0;
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({rom_enable, single_chip, shared_ram_onchip}, 3'b001);
    clk_en <= 1'b1;
    go(MODE_3);
    apb(1'b1, OFS_FLASH1, 32'h00000040);
    chk(flash_user_mode, 1'b0);
    complete_run();
  end
endmodule

// *** design/omps_pkg.sv ***
// Purpose: Shared constants and types for the operating mode pin function block.
// Assumes: APB with 32-bit data; every register takes one aligned word.
// Notes:   Port role codes are shared with the bench for checking roles.
package omps_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFS_SYS_CTRL  = 8'h04;
  localparam logic [7:0] OFS_FLASH1    = 8'h08;
  localparam logic [7:0] OFS_AREA_W    = 8'h0C;
  localparam logic [7:0] OFS_PORT_CFG  = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;

  // System control, flash and port config register fields and reset values.
  localparam int           SYS_ONCHIP_RAM_ENABLE_BIT_POS = 0;
  localparam int           SYS_EXPANSION_ENABLE_BIT_POS = 1;
  localparam int           SYS_HI_LSB   = 3;
  localparam logic [4:0]   SYS_HI_RST   = 5'h18;
  localparam int           FL1_SWE_POS  = 6;
  localparam int           PCFG_ABC_POS = 0;

  // Status register fields.
  localparam int ST_BUS16   = 0;
  localparam int ST_ROM     = 1;
  localparam int ST_SINGLE  = 2;
  localparam int ST_FLUSER  = 3;
  localparam int ST_BADMODE = 4;
  localparam int ST_READY   = 5;
  localparam int ST_ADV     = 6;
  localparam int ST_MODE    = 8;
  localparam int ST_ROLES   = 16;

  // Area width masks: one bit per area, 1 means 16-bit access.
  localparam logic [7:0] AREA_ALL16 = 8'hFF;
  localparam logic [7:0] AREA_ALL8  = 8'h00;

  // Mode pin settle wait and address space size in bits.
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam int         ADDR_BITS     = 24;

  // Pin role codes, two bits per port, ports A to H.
  typedef enum logic [1:0] {
    ROLE_GPIO = 2'h0,
    ROLE_ADDR = 2'h1,
    ROLE_DATA = 2'h2,
    ROLE_CTRL = 2'h3
  } omps_role_t;

  // Mode numbers as decoded from the four mode inputs.
  localparam logic [3:0] MODE_1  = 4'h1;
  localparam logic [3:0] MODE_2  = 4'h2;
  localparam logic [3:0] MODE_3  = 4'h3;
  localparam logic [3:0] MODE_4  = 4'h4;
  localparam logic [3:0] MODE_5  = 4'h5;
  localparam logic [3:0] MODE_6  = 4'h6;
  localparam logic [3:0] MODE_7  = 4'h7;
  localparam logic [3:0] MODE_10 = 4'hA;
  localparam logic [3:0] MODE_11 = 4'hB;
  localparam logic [3:0] MODE_12 = 4'hC;
  localparam logic [3:0] MODE_13 = 4'hD;
  localparam logic [3:0] MODE_14 = 4'hE;
  localparam logic [3:0] MODE_15 = 4'hF;
  localparam logic [3:0] MODE_NONE = 4'h0;
endpackage

// *** design/omps_top.sv ***
// Purpose: Operating mode decode, pin role select, bus width and map control.
// Assumes: Mode pins are static straps; software uses the APB registers.
// Notes:   One wait state on every APB access; roles settle after reset.
// Overview of operation
// - Every mode runs advanced addressing with a 16 Mbyte linear space.
// - Modes 1 and 2 disable ROM; A-C address, D-E data, F-H control.
// - Mode 1 starts 16-bit, falls to 8-bit only when all areas are 8-bit.
// - Mode 2 starts 8-bit, goes 16-bit with port E data when all are 16-bit.
// - Mode 4 enables on-chip ROM and fetches from it in area 0.
// - Mode 4 ports A-C start as inputs, address only when software sets it.
// - Modes 4 and 6 start 8-bit, go 16-bit when any area is 16-bit.
// - Modes 5 and 6 enable on-chip ROM, A-C address, D-E data.
// - Mode 5 starts 16-bit, drops to 8-bit when any area is 8-bit.
// - Mode 7 starts single-chip with ROM on, all ports GPIO, no addresses.
// - Mode 7 expansion bit set to 1 enters expanded mode with ROM roles.
// - Entering expanded mode from single-chip makes every area 16-bit.
// - Flash variant modes 4-7 enter user program mode when write bit is 1.
// - Mode 3 is flash boot, like mode 7, flash variant only.
// - Modes 10 and 11 mirror modes 4 and 7, flash variant only.
// - Modes 12 to 15 mirror modes 4 to 7, flash variant only.
// - Each port A-H role comes from the mode: GPIO, address, data, control.
// - Marked regions are external when expansion is 1, reserved when 0.
// - Shared RAM region: expanded uses RAM enable bit, else on-chip RAM.
// - Mode pin levels are captured into status bits on read; reset clears.
// - Expansion bit reads 1 fixed in modes 1,2,4-6; resets 0 writable in 3,7.
// - RAM enable bit disables RAM at 0, enables at 1, resets to 1.
`timescale 1ns/1ps
module omps_top #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  mode_select_pins,
  input  wire logic        boot_select_pin,
  output logic [15:0]      port_roles,
  output logic             rom_enable,
  output logic             bus_16bit,
  output logic             single_chip,
  output logic             advanced_mode,
  output logic             marked_region_external,
  output logic             shared_ram_onchip,
  output logic             flash_user_mode,
  output logic             mode_unsupported
);
  import omps_pkg::*;

  // Every mode reduces to one of six base modes.
  // Flash boot and user program modes share roles,
  // bus width rules and map control with a base mode.
  // They differ only in flash access, kept outside.
  // One decoder for all codes keeps a mode and its
  // mirror from drifting apart.
  // A code with no base mode is unsupported.
  // The decoder serves both the pins and the latch.
  // Decoded attributes of a mode.
  typedef struct packed {
    logic       valid;
    logic [3:0] base;
    logic       flash_only;
  } omps_attr_t;

  // One packed struct, so the clock enable and the
  // reset reach every flip-flop the same way.
  // The sync fields form the strap synchroniser.
  // Settle and ready gate the one-time capture.
  // Software bits, the APB reply and derived
  // levels follow; derived levels are registered
  // and so lag the bits they follow by one cycle.
  // All state of the block.
  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [1:0]  settle;
    logic        ready;
    logic [3:0]  mode;
    logic [2:0]  mode_status;
    logic        expansion_enable_bit;
    logic        onchip_ram_enable_bit;
    logic [4:0]  sys_hi;
    logic        software_write_enable_bit;
    logic [7:0]  area16;
    logic        abc_addr_en;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] roles;
    logic        rom_en;
    logic        bus16;
    logic        single;
    logic        ext_map;
    logic        ram_on;
    logic        fl_user;
    logic        bad;
    logic        adv;
  } omps_state_t;

  omps_state_t state_reg;
  omps_state_t state_next;

  // Maps each mode to the base mode whose behaviour it shares.
  function automatic omps_attr_t decode_mode(input logic [3:0] m);
    omps_attr_t a;
    a.valid      = 1'b1;
    a.flash_only = 1'b1;
    case (m)
      MODE_1, MODE_2, MODE_4, MODE_5, MODE_6, MODE_7: begin
        a.base       = m;
        a.flash_only = 1'b0;
      end
      MODE_3, MODE_11, MODE_15: a.base = MODE_7;
      MODE_10, MODE_12:         a.base = MODE_4;
      MODE_13:                  a.base = MODE_5;
      MODE_14:                  a.base = MODE_6;
      default: begin
        a.base  = MODE_NONE;
        a.valid = 1'b0;
      end
    endcase
    if (a.flash_only && !FLASH_VARIANT) begin
      a.valid = 1'b0;
      a.base  = MODE_NONE;
    end
    return a;
  endfunction

  // Only the single-chip base mode and unsupported codes let
  // software move the expansion bit; others fix it at one.
  // True when a base mode has its expansion bit fixed at one.
  function automatic logic expansion_enable_bit_fixed(input logic [3:0] b);
    return (b != MODE_7) && (b != MODE_NONE);
  endfunction

  // Only modes that start 16-bit begin all wide.
  // Areas that start 16-bit after reset for a base mode.
  function automatic logic [7:0] area_reset(input logic [3:0] b);
    return (b == MODE_1 || b == MODE_5) ? AREA_ALL16 : AREA_ALL8;
  endfunction

  // Decoded views of latch and pins, bus strobes.
  omps_attr_t attr;
  omps_attr_t pin_attr;
  logic       access;
  logic       wr;
  logic       rd;
  logic       fixed;
  logic       expanded;
  logic       abc_addr;
  logic [3:0] pin_mode;

  // Straps bear no relation to pclk and may still
  // move when reset is released.
  // Only stages two and three are compared; stage
  // one may be metastable and feeds stage two only.
  // A disagreement delays the capture one cycle.
  // Roles use the latched mode, so a strap moved
  // later cannot change them behind software.
  // Pin mode from the third stage; read only once the two last stages agree.
  assign pin_mode = state_reg.sync3;
  assign attr     = decode_mode(state_reg.mode);
  assign pin_attr = decode_mode(pin_mode);
  assign fixed    = expansion_enable_bit_fixed(attr.base);
  assign access   = psel && penable && !state_reg.pready;
  assign wr       = psel && penable && pwrite && state_reg.pready;
  assign rd       = access && !pwrite;

  // With the enable low the struct is copied as is,
  // so a stalled access waits for it to return.
  // Next state; all registers hold while the clock enable is low.
  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      state_next.sync1 = {boot_select_pin, mode_select_pins};
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;

      // The settle count lets the chain refill with
      // pin levels, as reset clears every stage.
      // Capture happens once; later pin moves show
      // only in the mode status bits.
      // Straps are caught once the chain has filled and settled.
      if (!state_reg.ready) begin
        if (state_reg.settle != SETTLE_CYCLES) begin
          state_next.settle = state_reg.settle + 2'h1;
        end else if (state_reg.sync2 == state_reg.sync3) begin
          state_next.ready = 1'b1;
          state_next.mode  = pin_attr.valid ? pin_mode : MODE_NONE;
          state_next.expansion_enable_bit = expansion_enable_bit_fixed(pin_attr.base);
          state_next.area16 = area_reset(pin_attr.base);
        end
      end

      // One wait state: the access phase is seen on
      // one edge and pready stands for one cycle.
      // A write lands on the edge at which the master
      // samples pready high, when the request is done.
      // Unmapped addresses raise pslverr, change nothing.
      // Register writes, taken on the edge that completes the access.
      if (access || wr) begin
        state_next.pready = access;
        case (paddr)
          OFS_MODE_CTRL, OFS_STATUS: begin
            if (rd && state_reg.sync2 == state_reg.sync3) begin
              state_next.mode_status = pin_mode[2:0];
            end
          end
          OFS_SYS_CTRL: begin
            if (wr) begin
              state_next.onchip_ram_enable_bit = pwdata[SYS_ONCHIP_RAM_ENABLE_BIT_POS];
              state_next.sys_hi = pwdata[SYS_HI_LSB +: 5];
              if (!fixed && state_reg.ready) begin
                state_next.expansion_enable_bit = pwdata[SYS_EXPANSION_ENABLE_BIT_POS];
                if (pwdata[SYS_EXPANSION_ENABLE_BIT_POS] && !state_reg.expansion_enable_bit) begin
                  state_next.area16 = AREA_ALL16;
                end
              end
            end
          end
          OFS_FLASH1: begin
            if (wr) begin
              state_next.software_write_enable_bit = pwdata[FL1_SWE_POS];
            end
          end
          OFS_AREA_W: begin
            if (wr) begin
              state_next.area16 = pwdata[7:0];
            end
          end
          OFS_PORT_CFG: begin
            if (wr) begin
              state_next.abc_addr_en = pwdata[PCFG_ABC_POS];
            end
          end
          default: state_next.pslverr = access;
        endcase
      end

      // Read data is zero outside an access (reads and writes), so no stale
      // word stands on prdata between transfers.
      state_next.prdata = 32'h0000_0000;
      if (access) begin
        case (paddr)
          OFS_MODE_CTRL: state_next.prdata[2:0] =
            (state_reg.sync2 == state_reg.sync3) ? pin_mode[2:0]
                                                 : state_reg.mode_status;
          OFS_SYS_CTRL: begin
            state_next.prdata[SYS_HI_LSB +: 5] = state_reg.sys_hi;
            state_next.prdata[SYS_EXPANSION_ENABLE_BIT_POS] = state_reg.expansion_enable_bit;
            state_next.prdata[SYS_ONCHIP_RAM_ENABLE_BIT_POS] = state_reg.onchip_ram_enable_bit;
          end
          OFS_FLASH1: state_next.prdata[FL1_SWE_POS] =
            state_reg.software_write_enable_bit;
          OFS_AREA_W:   state_next.prdata[7:0] = state_reg.area16;
          OFS_PORT_CFG: state_next.prdata[PCFG_ABC_POS] = state_reg.abc_addr_en;
          OFS_STATUS: begin
            state_next.prdata[ST_BUS16]   = state_reg.bus16;
            state_next.prdata[ST_ROM]     = state_reg.rom_en;
            state_next.prdata[ST_SINGLE]  = state_reg.single;
            state_next.prdata[ST_FLUSER]  = state_reg.fl_user;
            state_next.prdata[ST_BADMODE] = state_reg.bad;
            state_next.prdata[ST_READY]   = state_reg.ready;
            state_next.prdata[ST_ADV]     = state_reg.adv;
            state_next.prdata[ST_MODE +: 4]   = state_reg.mode;
            state_next.prdata[ST_ROLES +: 16] = state_reg.roles;
          end
          default: state_next.prdata = 32'h0000_0000;
        endcase
      end

      // Until the mode is latched the block idles:
      // ROM off, no expansion, all ports general I/O.
      // This keeps the bus quiet while straps settle.
      // Derived outputs, held in a safe state until the mode is known.
      state_next.bad     = state_reg.ready && !attr.valid;
      state_next.rom_en  = state_reg.ready &&
                           attr.base != MODE_1 && attr.base != MODE_2 &&
                           attr.base != MODE_NONE;
      state_next.single  = state_reg.ready && attr.valid &&
                           !state_reg.expansion_enable_bit;
      state_next.ext_map = state_reg.expansion_enable_bit;
      state_next.ram_on  = !state_reg.expansion_enable_bit ||
                           state_reg.onchip_ram_enable_bit;
      state_next.fl_user = FLASH_VARIANT && state_reg.ready &&
                           state_reg.software_write_enable_bit &&
                           attr.valid && attr.base >= MODE_4 &&
                           state_reg.mode != MODE_3 &&
                           state_reg.mode != MODE_10 &&
                           state_reg.mode != MODE_11;

      // Wide-start modes narrow on 8-bit areas, and
      // narrow-start modes widen on 16-bit areas.
      // Bus width follows the mode's all-area or any-area switching style.
      case (attr.base)
        MODE_1:  state_next.bus16 = |state_reg.area16;
        MODE_2:  state_next.bus16 = &state_reg.area16;
        MODE_5:  state_next.bus16 = &state_reg.area16;
        MODE_4, MODE_6, MODE_7: state_next.bus16 = |state_reg.area16;
        default: state_next.bus16 = 1'b0;
      endcase

      // Port E joins the data bus only on a 16-bit
      // bus; otherwise it stays general I/O.
      // Ports A to C wait for software in modes 4 and 7,
      // as users may want them as inputs after reset.
      // Port roles A (low bits) to H; single-chip and bad modes are all GPIO.
      state_next.roles = {8{ROLE_GPIO}};
      if (expanded) begin
        state_next.roles[1:0]   = abc_addr ? ROLE_ADDR : ROLE_GPIO;
        state_next.roles[3:2]   = abc_addr ? ROLE_ADDR : ROLE_GPIO;
        state_next.roles[5:4]   = abc_addr ? ROLE_ADDR : ROLE_GPIO;
        state_next.roles[7:6]   = ROLE_DATA;
        state_next.roles[9:8]   = state_next.bus16 ? ROLE_DATA : ROLE_GPIO;
        state_next.roles[11:10] = ROLE_CTRL;
        state_next.roles[13:12] = ROLE_CTRL;
        state_next.roles[15:14] = ROLE_CTRL;
      end
    end
  end

  // Kept as nets so the role table reads like a
  // list of port functions per mode.
  // Expanded operation and whether ports A to C carry the address bus.
  assign expanded = state_reg.ready && attr.valid &&
                    state_reg.expansion_enable_bit;
  assign abc_addr = (attr.base == MODE_4 || attr.base == MODE_7) ?
                    state_reg.abc_addr_en : 1'b1;

  // Reset clears all but the RAM enable, the
  // reserved system bits, the RAM level and the
  // addressing flag, which are preset.
  // Constants only, so it stays a plain clear.
  // State register; mode straps are never loaded under reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.onchip_ram_enable_bit <= 1'b1;
      state_reg.sys_hi <= SYS_HI_RST;
      state_reg.ram_on <= 1'b1;
      state_reg.adv <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Nothing follows the register, so the far side
  // sees no glitch while map or roles change.
  // Outputs straight from the state register.
  assign prdata                 = state_reg.prdata;
  assign pready                 = state_reg.pready;
  assign pslverr                = state_reg.pslverr;
  assign port_roles             = state_reg.roles;
  assign rom_enable             = state_reg.rom_en;
  assign bus_16bit              = state_reg.bus16;
  assign single_chip            = state_reg.single;
  assign advanced_mode          = state_reg.adv;
  assign marked_region_external = state_reg.ext_map;
  assign shared_ram_onchip      = state_reg.ram_on;
  assign flash_user_mode        = state_reg.fl_user;
  assign mode_unsupported       = state_reg.bad;

endmodule
